// *** idc_chk.sv ***
`timescale 1ns/1ps
module idc_chk (
    // Clock, reset and bus
    input wire logic               clk_i,
    input wire logic               rst_i,
    input wire logic               wb_cyc_i,
    input wire logic               wb_stb_i,
    input wire logic               wb_ack_o,
    // Decode request
    input wire logic               stage4_i,
    input wire logic [1:16]        opcode_i,
    input wire idc_pkg::idc_mode_t mode_i,
    input wire logic               generic_i,
    input wire logic               mem_ref_i,
    // Results
    input wire logic [11:0]        internal_b_bus_o,
    input wire logic               table_wr_pulse_o,
    input wire logic               dec_valid_o,
    input wire logic               length_ctl_bit_o,
    input wire logic               alternate_page_generic_o,
    input wire logic               addr_incr_two_o,
    input wire logic [1:0]         modified_reg_code_o,
    input wire logic               track_valid_o,
    input wire logic [3:0]         track_reg_o,
    input wire logic [3:0]         base_file_read_addr_o,
    input wire logic [2:0]         index_file_read_addr_o
);
    import idc_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [1:16] op_q1;
    logic [1:16] op_q2;
    // Opcode delayed to the result cycle
    always_ff @(posedge clk_i) begin
        op_q1 <= opcode_i;
        op_q2 <= op_q1;
    end
    sequence s_bus_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_dec_i;
        (stage4_i && mode_i == IDC_MODE_I) ##2 dec_valid_o;
    endsequence
    property p_ack;
        s_bus_req |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    property p_bus_idle;
        !table_wr_pulse_o |-> internal_b_bus_o == 12'h000;
    endproperty
    property p_valid;
        dec_valid_o |-> $past(stage4_i, 2);
    endproperty
    property p_len;
        (stage4_i && mem_ref_i) ##2 dec_valid_o |-> !length_ctl_bit_o;
    endproperty
    property p_alt;
        (stage4_i && !generic_i) ##2 dec_valid_o |-> !alternate_page_generic_o;
    endproperty
    property p_incr;
        (stage4_i && !mem_ref_i) ##2 dec_valid_o |-> !addr_incr_two_o;
    endproperty
    property p_trk;
        dec_valid_o |-> track_valid_o == (modified_reg_code_o != 2'h0);
    endproperty
    property p_odd;
        s_dec_i ##0 modified_reg_code_o == 2'h2 |-> track_reg_o == {1'b0, op_q2[7:8], 1'b1};
    endproperty
    property p_force;
        (stage4_i && mode_i != IDC_MODE_I) ##2 dec_valid_o |-> base_file_read_addr_o[3:2] == 2'h3;
    endproperty
    property p_idx;
        s_dec_i |-> index_file_read_addr_o == op_q2[12:14];
    endproperty
    a_ack: assert property (p_ack) else $error("bus ack not one cycle");
    a_bus_idle: assert property (p_bus_idle) else $error("bus busy off stage 8");
    a_valid: assert property (p_valid) else $error("result without request");
    a_len: assert property (p_len) else $error("length set on memory ref");
    a_alt: assert property (p_alt) else $error("alternate page off generic");
    a_incr: assert property (p_incr) else $error("increment off memory ref");
    a_trk: assert property (p_trk) else $error("track valid wrong");
    a_odd: assert property (p_odd) else $error("odd register wrong");
    a_force: assert property (p_force) else $error("base not forced");
    a_idx: assert property (p_idx) else $error("index address wrong");
endmodule
bind idc_top idc_chk idc_chk_i (.*);

// *** idc_defines.svh ***
`ifndef IDC_DEFINES_SVH
`define IDC_DEFINES_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define IDC_OFF_CTRL    8'h00
`define IDC_OFF_MADDR   8'h04
`define IDC_OFF_STAGE   8'h08
`define IDC_OFF_WRITE   8'h0C
`define IDC_OFF_STATUS  8'h10

// Control register fields
`define IDC_CTRL_LOAD   0
`define IDC_CTRL_BLK    1
`define IDC_CTRL_DBL    2

// Status register fields
`define IDC_ST_BUSY     0
`define IDC_ST_LOAD     1
`define IDC_ST_DBL      2
`define IDC_ST_CNT_LSB  4

// Reset values
`define IDC_MADDR_RST   12'h000
`define IDC_STAGE_RST   20'h00000

// ----------------------------------------
// Table word layout
// ----------------------------------------
`define IDC_W_CTL_LSB   12
`define IDC_W_CTL_MSB   17

// Control bit index inside the six-bit field
`define IDC_C_LEN       0
`define IDC_C_ALT       1
`define IDC_C_BC        2
`define IDC_C_MOD_HI    3
`define IDC_C_MOD_LO    4
`define IDC_C_EXP       5

// Modified register codes
`define IDC_MOD_NONE    2'h0
`define IDC_MOD_XB      2'h1
`define IDC_MOD_Y_ODD   2'h2
`define IDC_MOD_X_DEST  2'h3

// Base file addresses
`define IDC_BF_Y        4'h5
`define IDC_BF_X        4'h7
`define IDC_BF_FLR0     4'h9
`define IDC_BF_FLR1     4'hB
`define IDC_BF_PB       4'hC
`define IDC_BF_XB       4'hF

// Register-to-register float selectors, opcode bits 12 to 16
`define IDC_RR_FLR0     5'h06
`define IDC_RR_FLR1     5'h0E

// Index file selections outside I mode
`define IDC_XF_Y        3'h5
`define IDC_XF_X        3'h7

// Pipeline stage at which the table is written
`define IDC_WR_STAGE    4'h8

`endif

// *** idc_pkg.sv ***
package idc_pkg;

    // Table load sequencer, one bit changes per step except WRITE to IDLE
    typedef enum logic [1:0] {
        IDC_IDLE  = 2'h0,
        IDC_XFER  = 2'h1,
        IDC_WRITE = 2'h3
    } idc_state_t;

    // Addressing mode of the machine
    typedef enum logic [1:0] {
        IDC_MODE_S = 2'h0,
        IDC_MODE_R = 2'h1,
        IDC_MODE_V = 2'h2,
        IDC_MODE_I = 2'h3
    } idc_mode_t;

    // Whole register state of the decode control block except the table and its read word rd_word
    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
        logic        load_mode;
        logic        blk_sel;
        logic        dbl_key;
        logic [11:0] micro_address_reg;
        logic [19:0] stage_data;
        idc_state_t  fsm;
        logic [3:0]  stage;
        logic [12:0] wr_count;
        logic        wr_pulse;
        logic [12:0] wr_addr;
        logic        rd_pend;
        logic        p_gen;
        logic        p_mem;
        logic        p_i;
        logic [2:0]  p_dst;
        logic [3:0]  p_base;
        logic [2:0]  p_index;
        logic        p_pcl;
        logic        len;
        logic        altgen;
        logic        incr2;
        logic        bc_permit;
        logic [1:0]  mod_code;
        logic        exp_track;
        logic        trk_valid;
        logic [3:0]  trk_reg;
        logic [11:0] entry;
        logic        dec_valid;
        logic [3:0]  base_addr;
        logic [2:0]  index_addr;
        logic        pc_low_sel;
        logic [11:0] bbus;
    } idc_regs_t;

endpackage

// *** idc_regaddr.sv ***
`timescale 1ns/1ps
`include "idc_defines.svh"

module idc_regaddr (
    // Instruction context
    input  wire logic        imode_i,
    input  wire logic        reg_reg_i,
    input  wire logic        generic_i,
    input  wire logic        indirect_ph1_i,
    input  wire logic        other_base_i,
    input  wire logic [1:0]  mem_base_i,
    input  wire logic        sector_rel_i,
    input  wire logic        proc_rel_i,
    input  wire logic [1:16] opcode_i,
    // Register file read addresses
    output logic      [3:0]  base_addr_o,
    output logic      [2:0]  index_addr_o,
    output logic             pc_low_sel_o
);
    logic       force_base;
    logic [4:0] rr_sel;

    // Base file address selection
    always_comb begin
        force_base = !imode_i || !reg_reg_i;
        rr_sel     = opcode_i[12:16];
        if (force_base) begin
            if (generic_i || indirect_ph1_i || !other_base_i) begin
                base_addr_o = `IDC_BF_PB;
            end else begin
                base_addr_o = {2'h3, mem_base_i};
            end
        end else if (rr_sel == `IDC_RR_FLR0) begin
            base_addr_o = `IDC_BF_FLR0;
        end else if (rr_sel == `IDC_RR_FLR1) begin
            base_addr_o = `IDC_BF_FLR1;
        end else begin
            base_addr_o = {1'b0, opcode_i[12:14]};
        end
    end

    // Index file address and program counter low substitution
    always_comb begin
        if (imode_i) begin
            index_addr_o = opcode_i[12:14];
        end else begin
            index_addr_o = opcode_i[2] ? `IDC_XF_X : `IDC_XF_Y;
        end
        pc_low_sel_o = sector_rel_i || proc_rel_i || generic_i;
    end

endmodule

// *** idc_top.sv ***
`timescale 1ns/1ps
`include "idc_defines.svh"


module idc_top
    import idc_pkg::*;
#(
    parameter int ADDR_W = 13,
    parameter int WORD_W = 20
) (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // Decode request
    input  wire logic              system_clear_i,
    input  wire logic              stage4_i,
    input  wire logic [ADDR_W-1:0] dn_addr_i,
    input  wire logic [1:16]       opcode_i,
    input  wire idc_pkg::idc_mode_t mode_i,
    input  wire logic              reg_reg_i,
    input  wire logic              generic_i,
    input  wire logic              mem_ref_i,
    input  wire logic              indirect_ph1_i,
    input  wire logic              other_base_i,
    input  wire logic [1:0]        mem_base_i,
    input  wire logic              sector_rel_i,
    input  wire logic              proc_rel_i,
    // Table load buses
    output logic      [11:0]       internal_b_bus_o,
    output logic      [9:0]        data_bus_high_o,
    output logic      [9:0]        data_bus_low_o,
    output logic                   table_wr_pulse_o,
    // Decode results
    output logic                   dec_valid_o,
    output logic      [11:0]       entry_o,
    output logic                   length_ctl_bit_o,
    output logic                   alternate_page_generic_o,
    output logic                   addr_incr_two_o,
    output logic                   branch_cache_permit_bit_o,
    output logic      [1:0]        modified_reg_code_o,
    output logic                   exponent_track_bit_o,
    output logic                   track_valid_o,
    output logic      [3:0]        track_reg_o,
    // Register file addresses
    output logic      [3:0]        base_file_read_addr_o,
    output logic      [2:0]        index_file_read_addr_o,
    output logic                   program_counter_low_sel_o
);

    // ----------------------------------------
    // Functions
    // ----------------------------------------

    // Byte-lane merge of a bus write
    function automatic logic [31:0] wb_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  sel
    );
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // Microsequencer conversion of the micro address to a table address
    function automatic logic [12:0] table_addr(
        input logic        dbl,
        input logic        blk,
        input logic [11:0] micro_address_reg
    );
        return {dbl, blk | micro_address_reg[11], micro_address_reg[10:0]};
    endfunction

    // ----------------------------------------
    // Storage
    // ----------------------------------------

    logic [WORD_W-1:0] dn_mem [0:(1<<ADDR_W)-1];
    logic [WORD_W-1:0] rd_word;
    idc_regs_t         r;
    idc_regs_t         next_r;

    logic [3:0]  ra_base;
    logic [2:0]  ra_index;
    logic        ra_pcl;
    logic [5:0]  ctl;
    logic        req;
    logic        wr_req;
    logic [31:0] ctrl_word;
    logic [31:0] merged;

    // Register file address generation
    idc_regaddr idc_regaddr_i (
        .imode_i        (mode_i == IDC_MODE_I),
        .reg_reg_i      (reg_reg_i),
        .generic_i      (generic_i),
        .indirect_ph1_i (indirect_ph1_i),
        .other_base_i   (other_base_i),
        .mem_base_i     (mem_base_i),
        .sector_rel_i   (sector_rel_i),
        .proc_rel_i     (proc_rel_i),
        .opcode_i       (opcode_i),
        .base_addr_o    (ra_base),
        .index_addr_o   (ra_index),
        .pc_low_sel_o   (ra_pcl)
    );

    // Bus request qualifiers and control word view
    assign req       = wb_cyc_i && wb_stb_i && !r.ack;
    assign wr_req    = req && wb_we_i;
    assign ctl       = rd_word[`IDC_W_CTL_MSB:`IDC_W_CTL_LSB];
    assign ctrl_word = {29'h0, r.dbl_key, r.blk_sel, r.load_mode};
    assign merged    = wb_merge(ctrl_word, wb_dat_i, wb_sel_i);

    // ----------------------------------------
    // Table memory
    // ----------------------------------------

    // One write pulse stores the whole word
    always_ff @(posedge clk_i) begin
        if (r.wr_pulse) begin
            dn_mem[r.wr_addr] <= r.stage_data;
        end
    end

    // Stage 4 lookup, held off during loading
    always_ff @(posedge clk_i) begin
        if (stage4_i && !r.load_mode) begin
            rd_word <= dn_mem[dn_addr_i];
        end
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------

    always_comb begin
        next_r          = r;
        next_r.ack      = req;
        next_r.wr_pulse = 1'b0;
        next_r.rd_pend  = 1'b0;

        // Register reads
        next_r.dat = 32'h0;
        if (req && !wb_we_i) begin
            case (wb_adr_i)
                `IDC_OFF_CTRL: begin
                    next_r.dat = ctrl_word;
                end
                `IDC_OFF_MADDR: begin
                    next_r.dat = {20'h0, r.micro_address_reg};
                end
                `IDC_OFF_STAGE: begin
                    next_r.dat = {12'h0, r.stage_data};
                end
                `IDC_OFF_STATUS: begin
                    next_r.dat[`IDC_ST_BUSY] = (r.fsm != IDC_IDLE);
                    next_r.dat[`IDC_ST_LOAD] = r.load_mode;
                    next_r.dat[`IDC_ST_DBL]  = r.dbl_key;
                    next_r.dat[`IDC_ST_CNT_LSB +: 13] = r.wr_count;
                end
                default: begin
                    next_r.dat = 32'h0;
                end
            endcase
        end

        // Register writes
        if (wr_req) begin
            case (wb_adr_i)
                `IDC_OFF_CTRL: begin
                    next_r.load_mode = merged[`IDC_CTRL_LOAD];
                    next_r.blk_sel   = merged[`IDC_CTRL_BLK];
                    next_r.dbl_key   = merged[`IDC_CTRL_DBL];
                    if (!merged[`IDC_CTRL_LOAD]) begin
                        next_r.wr_count = 13'h0;
                    end
                end
                `IDC_OFF_MADDR: begin
                    next_r.micro_address_reg = 12'(wb_merge({20'h0, r.micro_address_reg}, wb_dat_i,
                                              wb_sel_i));
                end
                `IDC_OFF_STAGE: begin
                    next_r.stage_data = 20'(wb_merge({12'h0, r.stage_data},
                                                     wb_dat_i, wb_sel_i));
                end
                default: begin
                end
            endcase
        end

        // System clear drops the double precision key
        if (system_clear_i) begin
            next_r.dbl_key   = 1'b0;
            next_r.load_mode = 1'b0;
        end

        // Table load sequencer
        case (r.fsm)
            IDC_IDLE: begin
                if (wr_req && wb_adr_i == `IDC_OFF_WRITE && r.load_mode) begin
                    next_r.fsm   = IDC_XFER;
                    next_r.stage = 4'h1;
                end
            end
            IDC_XFER: begin
                next_r.stage = r.stage + 4'h1;
                if (r.stage + 4'h1 == `IDC_WR_STAGE) begin
                    next_r.fsm      = IDC_WRITE;
                    next_r.wr_pulse = 1'b1;
                    next_r.wr_addr  = table_addr(r.dbl_key, r.blk_sel,
                                                 r.micro_address_reg);
                end
            end
            IDC_WRITE: begin
                next_r.fsm      = IDC_IDLE;
                next_r.stage    = 4'h0;
                next_r.wr_count = r.wr_count + 13'h1;
            end
            default: begin
                next_r.fsm   = IDC_IDLE;
                next_r.stage = 4'h0;
            end
        endcase
        if (system_clear_i) begin
            next_r.fsm      = IDC_IDLE;
            next_r.stage    = 4'h0;
            next_r.wr_pulse = 1'b0;
        end
        // Micro address shown on the internal bus with the write pulse only
        next_r.bbus = next_r.wr_pulse ? r.micro_address_reg : 12'h000;

        // Stage 4 capture of the instruction context
        if (stage4_i && !r.load_mode) begin
            next_r.rd_pend = 1'b1;
            next_r.p_gen   = generic_i;
            next_r.p_mem   = mem_ref_i;
            next_r.p_i     = (mode_i == IDC_MODE_I);
            next_r.p_dst   = opcode_i[7:9];
            next_r.p_base  = ra_base;
            next_r.p_index = ra_index;
            next_r.p_pcl   = ra_pcl;
        end

        // Decode of the looked-up control bits
        next_r.dec_valid = r.rd_pend && !r.load_mode;
        if (r.rd_pend && !r.load_mode) begin
            next_r.entry      = rd_word[11:0];
            next_r.len        = r.p_mem ? 1'b0 : ctl[`IDC_C_LEN];
            next_r.altgen     = r.p_gen & ctl[`IDC_C_ALT];
            next_r.incr2      = r.p_mem & ctl[`IDC_C_ALT];
            next_r.bc_permit  = ctl[`IDC_C_BC];
            next_r.mod_code   = {ctl[`IDC_C_MOD_HI], ctl[`IDC_C_MOD_LO]};
            next_r.exp_track  = ctl[`IDC_C_EXP];
            next_r.base_addr  = r.p_base;
            next_r.index_addr = r.p_index;
            next_r.pc_low_sel = r.p_pcl;
            next_r.trk_valid  = 1'b1;
            case ({ctl[`IDC_C_MOD_HI], ctl[`IDC_C_MOD_LO]})
                `IDC_MOD_XB: begin
                    next_r.trk_reg = `IDC_BF_XB;
                end
                `IDC_MOD_Y_ODD: begin
                    next_r.trk_reg = r.p_i ? {1'b0, r.p_dst[2:1], 1'b1}
                                           : `IDC_BF_Y;
                end
                `IDC_MOD_X_DEST: begin
                    next_r.trk_reg = r.p_i ? {1'b0, r.p_dst}
                                           : `IDC_BF_X;
                end
                default: begin
                    next_r.trk_valid = 1'b0;
                    next_r.trk_reg   = 4'h0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r            <= '0;
            r.fsm        <= IDC_IDLE;
            r.micro_address_reg        <= `IDC_MADDR_RST;
            r.stage_data <= `IDC_STAGE_RST;
            r.base_addr  <= `IDC_BF_PB;
        end else begin
            r <= next_r;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------

    // Bus answer
    assign wb_ack_o = r.ack;
    assign wb_dat_o = r.dat;

    // Micro address on the internal bus during stage 8 only
    assign internal_b_bus_o = r.bbus;
    assign data_bus_high_o  = r.stage_data[19:10];
    assign data_bus_low_o   = r.stage_data[9:0];
    assign table_wr_pulse_o = r.wr_pulse;

    // Decode results
    assign dec_valid_o               = r.dec_valid;
    assign entry_o                   = r.entry;
    assign length_ctl_bit_o          = r.len;
    assign alternate_page_generic_o  = r.altgen;
    assign addr_incr_two_o           = r.incr2;
    assign branch_cache_permit_bit_o = r.bc_permit;
    assign modified_reg_code_o       = r.mod_code;
    assign exponent_track_bit_o      = r.exp_track;
    assign track_valid_o             = r.trk_valid;
    assign track_reg_o               = r.trk_reg;

    // Register file addresses
    assign base_file_read_addr_o     = r.base_addr;
    assign index_file_read_addr_o    = r.index_addr;
    assign program_counter_low_sel_o = r.pc_low_sel;

endmodule

// *** idc_useq_model.sv ***
`timescale 1ns/1ps
module idc_useq_model (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Bench request
    input  wire logic        req_i,
    input  wire logic        dbl_i,
    input  wire logic        blk_i,
    input  wire logic [11:0] rma_i,
    // Decode request
    output logic             stage4_o,
    output logic      [12:0] dn_addr_o,
    // Table write bus
    input  wire logic [11:0] bus_i,
    input  wire logic        wr_pulse_i,
    output logic      [11:0] seen_rma_o
);
    logic [12:0] addr;
    // Table address from key, block select and micro address
    assign addr = {dbl_i, blk_i | rma_i[11], rma_i[10:0]};
    // One strobe per request; address toggles when idle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stage4_o   <= 1'b0;
            dn_addr_o  <= 13'h0000;
            seen_rma_o <= 12'h000;
        end else begin
            stage4_o  <= req_i;
            dn_addr_o <= req_i ? addr : ~dn_addr_o;
            if (wr_pulse_i) begin
                seen_rma_o <= bus_i;
            end
        end
    end
endmodule

// *** instruction_decode_control_tb_top.sv ***
`timescale 1ns/1ps
`include "idc_defines.svh"
module instruction_decode_control_tb_top;
    import idc_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, clr = 1'b0, req = 1'b0;
    logic        gen = 1'b0, mem = 1'b0, rr = 1'b0, sr = 1'b0, ob = 1'b0, ind = 1'b0;
    logic        dbl = 1'b0, blk = 1'b0, st4, wrp, ack, dv, len, alt, inc, bc, ex, tv, pcs;
    logic [3:0]  sel = 4'h0, trk, base;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat = 32'h0, rdat, q;
    logic [1:16] op = 16'h0000;
    logic [12:0] dna;
    logic [11:0] bbus, seen, entry;
    logic [9:0]  dbh, dbl_bus;
    logic [2:0]  idx;
    logic [1:0]  mc;
    idc_mode_t   mode = IDC_MODE_S;
    int          err_count = 0, checked = 0;
    always #12.5 clk_i = ~clk_i;
    idc_top idc_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .system_clear_i(clr), .stage4_i(st4), .dn_addr_i(dna),
        .opcode_i(op), .mode_i(mode), .reg_reg_i(rr), .generic_i(gen), .mem_ref_i(mem),
        .indirect_ph1_i(ind), .other_base_i(ob), .mem_base_i(2'h1), .sector_rel_i(sr),
        .proc_rel_i(ind), .internal_b_bus_o(bbus), .data_bus_high_o(dbh),
        .data_bus_low_o(dbl_bus), .table_wr_pulse_o(wrp), .dec_valid_o(dv),
        .entry_o(entry), .length_ctl_bit_o(len), .alternate_page_generic_o(alt),
        .addr_incr_two_o(inc), .branch_cache_permit_bit_o(bc), .modified_reg_code_o(mc),
        .exponent_track_bit_o(ex), .track_valid_o(tv), .track_reg_o(trk),
        .base_file_read_addr_o(base), .index_file_read_addr_o(idx),
        .program_counter_low_sel_o(pcs));
    idc_useq_model idc_useq_model_i (.clk_i(clk_i), .rst_i(rst_i), .req_i(req),
        .dbl_i(dbl), .blk_i(blk), .rma_i(12'h123), .stage4_o(st4), .dn_addr_o(dna),
        .bus_i(bbus), .wr_pulse_i(wrp), .seen_rma_o(seen));
    // Compare and count
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask
    // One classic bus cycle; read data lands in q
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        sel <= s;
        @(posedge clk_i);
        while (ack !== 1'b1) begin
            @(posedge clk_i);
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        @(posedge clk_i);
    endtask
    // Load one table word at micro address 0x123
    task automatic ld(input logic d, input logic b, input logic [19:0] w);
        wb(1'b1, `IDC_OFF_CTRL, {29'h0, d, b, 1'b1}, 4'hF);
        wb(1'b1, `IDC_OFF_MADDR, 32'h123, 4'hF);
        wb(1'b1, `IDC_OFF_STAGE, {12'h0, w}, 4'hF);
        wb(1'b1, `IDC_OFF_WRITE, 32'h0, 4'hF);
        while (wrp !== 1'b1) begin
            @(posedge clk_i);
        end
        chk("stage8 bus", 32'h123, {20'h0, bbus});
        chk("data buses", {12'h0, w}, {12'h0, dbh, dbl_bus});
        @(posedge clk_i);
        wb(1'b0, `IDC_OFF_STATUS, 32'h0, 4'hF);
        chk("busy", 32'h0, {31'h0, q[0]});
        $display("test load %h done", w);
    endtask
    // Expected decode bits from a table word
    function automatic logic [31:0] dexp(logic [19:0] w, logic g, logic m, logic [3:0] t);
        dexp = {w[11:0], w[12] & ~m, w[13] & g, w[13] & m, w[14], w[15], w[16], w[17],
                w[15] | w[16], t};
    endfunction
    // One decode through the partner; e = {track, base}, f = {index, pc select}
    task automatic dec(input idc_mode_t m, input logic [5:0] c, input logic [1:16] o,
                       input logic [1:0] r, input logic [19:0] w, input logic [7:0] e,
                       input logic [3:0] f);
        mode <= m;
        {gen, mem, rr, sr, ob, ind} <= c;
        op <= o;
        {dbl, blk} <= r;
        req <= 1'b1;
        @(posedge clk_i);
        req <= 1'b0;
        while (dv !== 1'b1) begin
            @(posedge clk_i);
        end
        chk("decode bits", dexp(w, c[5], c[4], e[7:4]),
            {8'h0, entry, len, alt, inc, bc, mc, ex, tv, trk});
        chk("file addr", {20'h0, e, f}, {20'h0, trk, base, idx, pcs});
        $display("test decode %h done", w);
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (5000) @(posedge clk_i);
        err_count++;
        stop_test();
    end
    // Main sequence
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk("reset base", 32'hC, {28'h0, base});
        wb(1'b0, 8'h20, 32'h0, 4'hF);
        chk("unmapped", 32'h0, q);
        ld(1'b0, 1'b0, 20'hB3ABC);
        ld(1'b0, 1'b1, 20'h0F555);
        ld(1'b1, 1'b0, 20'h1C0F0);
        chk("write count", 32'h3, {19'h0, q[16:4]});
        chk("seen rma", 32'h123, {20'h0, seen});
        wb(1'b1, `IDC_OFF_MADDR, 32'h0000_0A00, 4'h2);
        wb(1'b0, `IDC_OFF_MADDR, 32'h0, 4'hF);
        chk("byte lane", 32'h0000_0A23, q);
        req <= 1'b1;
        @(posedge clk_i);
        req <= 1'b0;
        repeat (6) begin
            @(posedge clk_i);
            chk("refused", 32'h0, {31'h0, dv});
        end
        clr <= 1'b1;
        @(posedge clk_i);
        clr <= 1'b0;
        wb(1'b0, `IDC_OFF_STATUS, 32'h0, 4'hF);
        chk("clear key", 32'h0, {29'h0, q[2:0]});
        dec(IDC_MODE_V, 6'h20, 16'h4000, 2'h0, 20'hB3ABC, 8'hFC, 4'hF);
        dec(IDC_MODE_R, 6'h12, 16'h0000, 2'h1, 20'h0F555, 8'h5D, 4'hA);
        dec(IDC_MODE_I, 6'h08, 16'h0306, 2'h2, 20'h1C0F0, 8'h69, 4'h2);
        dec(IDC_MODE_I, 6'h14, 16'h011C, 2'h1, 20'h0F555, 8'h3C, 4'hF);
        dec(IDC_MODE_I, 6'h08, 16'h000E, 2'h0, 20'hB3ABC, 8'hFB, 4'h6);
        dec(IDC_MODE_I, 6'h08, 16'h0014, 2'h2, 20'h1C0F0, 8'h05, 4'hA);
        dec(IDC_MODE_I, 6'h11, 16'h0000, 2'h1, 20'h0F555, 8'h1C, 4'h1);
        stop_test();
    end
endmodule
